// [common/vasm_pkg.sv]
package vasm_pkg;

    // Address layout
    localparam logic [31:0] VASM_KSEG_CD_BASE = 32'h8000_0000;
    localparam logic [31:0] VASM_KSEG_UD_BASE = 32'ha000_0000;
    localparam logic [31:0] VASM_KSEG_M_BASE = 32'hc000_0000;
    localparam logic [31:0] VASM_TOP_DIRECT_BASE = 32'hff00_0000;
    localparam logic [31:0] VASM_DIRECT_MASK = 32'h1fff_ffff;
    localparam logic [31:0] VASM_BOOT_VECTOR = 32'hbfc0_0000;
    localparam logic [31:0] VASM_SDRAM_LAST = 32'h03ff_ffff;
    localparam logic [31:0] VASM_FLASH_BASE = 32'h1fc0_0000;
    localparam logic [31:0] VASM_FLASH_LAST = 32'h1fff_ffff;
    localparam logic [31:0] VASM_FLASH_EXT_BASE = 32'h1e40_0000;
    localparam logic [31:0] VASM_FLASH_EXT_LAST = 32'h1eff_ffff;

    // Peripheral region bases, size-aligned, non-overlapping
    localparam logic [31:0] VASM_SFR_BASE = 32'h1d01_0000;
    localparam logic [31:0] VASM_MEMC_BASE = 32'h1d01_1000;
    localparam logic [31:0] VASM_CRYPTO_BASE = 32'h1d10_0000;
    localparam logic [31:0] VASM_MIC_BASE = 32'h1d18_0000;
    localparam logic [31:0] VASM_ETH0_BASE = 32'h1d20_0000;
    localparam logic [31:0] VASM_VOICE_BASE = 32'h1d28_0000;
    localparam logic [31:0] VASM_ETH1_BASE = 32'h1d30_0000;
    localparam logic [31:0] VASM_WLAN_BASE = 32'h1d40_0000;
    localparam logic [31:0] VASM_PCI_IO_BASE = 32'h1d50_0000;
    localparam logic [31:0] VASM_PCI_M01_BASE = 32'h1d60_0000;
    localparam logic [31:0] VASM_PCI_M2_BASE = 32'h1d61_0000;
    localparam logic [31:0] VASM_PCI_M3_BASE = 32'h1000_0000;
    localparam logic [31:0] VASM_PCI_CFG_BASE = 32'h1d70_0000;

    // Region sizes as masks of the offset bits, except 208M, which is the last offset of a range
    localparam logic [31:0] VASM_SZ_4K = 32'h0000_0fff;
    localparam logic [31:0] VASM_SZ_64K = 32'h0000_ffff;
    localparam logic [31:0] VASM_SZ_512K = 32'h0007_ffff;
    localparam logic [31:0] VASM_SZ_1M = 32'h000f_ffff;
    localparam logic [31:0] VASM_SZ_208M = 32'h0cff_ffff;

    localparam int VASM_TLB_ENTRIES = 16;
    localparam int VASM_PAGE_BITS = 12;

    typedef enum logic [1:0] {
        VASM_SEG_USER = 2'h0,
        VASM_SEG_KCD = 2'h1,
        VASM_SEG_KUD = 2'h3,
        VASM_SEG_KMAP = 2'h2
    } vasm_seg_t;

    typedef enum logic [4:0] {
        VASM_TGT_NONE = 5'h00,
        VASM_TGT_SDRAM = 5'h01,
        VASM_TGT_FLASH = 5'h02,
        VASM_TGT_SFR = 5'h03,
        VASM_TGT_MEMC = 5'h04,
        VASM_TGT_CRYPTO = 5'h05,
        VASM_TGT_MIC = 5'h06,
        VASM_TGT_ETH0 = 5'h07,
        VASM_TGT_VOICE = 5'h08,
        VASM_TGT_ETH1 = 5'h09,
        VASM_TGT_WLAN = 5'h0a,
        VASM_TGT_PCI_IO = 5'h0b,
        VASM_TGT_PCI_M01 = 5'h0c,
        VASM_TGT_PCI_M2 = 5'h0d,
        VASM_TGT_PCI_M3 = 5'h0e,
        VASM_TGT_PCI_CFG0 = 5'h10,
        VASM_TGT_PCI_CFG1 = 5'h11,
        VASM_TGT_PCI_CFG2 = 5'h12,
        VASM_TGT_PCI_CFG3 = 5'h13,
        VASM_TGT_TOP = 5'h14
    } vasm_tgt_t;

    // TLB entry written by refill software
    typedef struct packed {
        logic valid;
        logic [19:0] vpn;
        logic [19:0] pfn;
        logic [5:0] pid;
        logic writable;
        logic cacheable;
    } vasm_tlb_entry_t;

    // Request from the core
    typedef struct packed {
        logic valid;
        logic [31:0] vaddr;
        logic write;
        logic kernel;
        logic [5:0] pid;
    } vasm_req_t;

    // Translated answer
    typedef struct packed {
        logic valid;
        logic [31:0] paddr;
        vasm_seg_t seg;
        vasm_tgt_t target;
        logic cacheable;
        logic pci_cfg;
        logic pci_io;
        logic exc;
    } vasm_rsp_t;

endpackage : vasm_pkg

// [rtl/vasm_mapper.sv]
`timescale 1ns/100ps

module vasm_mapper
    import vasm_pkg::*;
#(
    parameter int ENTRIES = VASM_TLB_ENTRIES
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire vasm_req_t req_in,
    input wire logic tlb_we_in,
    input wire logic [$clog2(ENTRIES)-1:0] tlb_idx_in,
    input wire vasm_tlb_entry_t tlb_entry_in,
    output logic [31:0] boot_pc_out,
    output vasm_rsp_t rsp_out
);

    typedef struct packed {
        vasm_tlb_entry_t [ENTRIES-1:0] tlb;
        vasm_rsp_t rsp;
    } vasm_state_t;

    vasm_state_t st_r;
    vasm_state_t st_nxt;

    logic [ENTRIES-1:0] hit_vec;
    vasm_tlb_entry_t hit_e;
    logic hit;
    logic map_va;

    //--------------------------------------------------------------
    // TLB match
    //--------------------------------------------------------------
    // per-entry compare
    genvar gi;
    generate
        for (gi = 0; gi < ENTRIES; gi++) begin : g_match
            assign hit_vec[gi] = st_r.tlb[gi].valid
                && st_r.tlb[gi].vpn == req_in.vaddr[31:VASM_PAGE_BITS]
                && st_r.tlb[gi].pid == req_in.pid;
        end
    endgenerate

    // Lowest matching index wins; software should avoid duplicates
    always_comb begin
        hit_e = '0;
        hit = 1'b0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                hit_e = st_r.tlb[i];
                hit = 1'b1;
            end
        end
    end

    // Region test helper: aligned base, size mask
    function automatic logic in_rgn(input logic [31:0] a, input logic [31:0] b,
                                    input logic [31:0] m);
        in_rgn = (a & ~m) == b;
    endfunction : in_rgn

    //--------------------------------------------------------------
    // Translation and decode
    //--------------------------------------------------------------
    always_comb begin
        logic [31:0] va;
        logic [31:0] pa;
        vasm_seg_t seg;
        logic mapped;
        logic konly;
        logic cach;
        logic exc;
        vasm_tgt_t tgt;
        va = req_in.vaddr;
        seg = VASM_SEG_USER;
        pa = '0;
        mapped = 1'b0;
        konly = 1'b1;
        cach = 1'b1;
        exc = 1'b0;
        tgt = VASM_TGT_NONE;
        st_nxt = st_r;
        if (va < VASM_KSEG_CD_BASE) begin
            seg = VASM_SEG_USER;
            konly = 1'b0;
            mapped = 1'b1;
        end else if (va < VASM_KSEG_UD_BASE) begin
            seg = VASM_SEG_KCD;
        end else if (va < VASM_KSEG_M_BASE) begin
            seg = VASM_SEG_KUD;
            cach = 1'b0;
        end else begin
            seg = VASM_SEG_KMAP;
            mapped = va < VASM_TOP_DIRECT_BASE;
        end
        // low 512M alias or identity at top
        if (!mapped) begin
            pa = (seg == VASM_SEG_KMAP) ? va : (va & VASM_DIRECT_MASK);
        end else begin
            pa = {hit_e.pfn, va[VASM_PAGE_BITS-1:0]};
            cach = hit_e.cacheable;
        end
        if (konly && !req_in.kernel) begin
            exc = 1'b1;
        end
        if (mapped && (!hit || (req_in.write && !hit_e.writable))) begin
            exc = 1'b1;
        end
        // peripherals only from the uncached direct segment
        if (seg == VASM_SEG_KMAP && !mapped) begin
            tgt = VASM_TGT_TOP;
        end else if (pa <= VASM_SDRAM_LAST) begin
            tgt = VASM_TGT_SDRAM;
        end else if (pa >= VASM_FLASH_BASE && pa <= VASM_FLASH_LAST) begin
            tgt = VASM_TGT_FLASH;
        end else if (pa >= VASM_FLASH_EXT_BASE && pa <= VASM_FLASH_EXT_LAST) begin
            tgt = VASM_TGT_FLASH;
        end else if (seg == VASM_SEG_KUD) begin
            if (in_rgn(pa, VASM_SFR_BASE, VASM_SZ_4K)) begin
                tgt = VASM_TGT_SFR;
            end else if (in_rgn(pa, VASM_MEMC_BASE, VASM_SZ_4K)) begin
                tgt = VASM_TGT_MEMC;
            end else if (in_rgn(pa, VASM_CRYPTO_BASE, VASM_SZ_512K)) begin
                tgt = VASM_TGT_CRYPTO;
            end else if (in_rgn(pa, VASM_MIC_BASE, VASM_SZ_512K)) begin
                tgt = VASM_TGT_MIC;
            end else if (in_rgn(pa, VASM_ETH0_BASE, VASM_SZ_512K)) begin
                tgt = VASM_TGT_ETH0;
            end else if (in_rgn(pa, VASM_VOICE_BASE, VASM_SZ_512K)) begin
                tgt = VASM_TGT_VOICE;
            end else if (in_rgn(pa, VASM_ETH1_BASE, VASM_SZ_1M)) begin
                tgt = VASM_TGT_ETH1;
            end else if (in_rgn(pa, VASM_WLAN_BASE, VASM_SZ_1M)) begin
                tgt = VASM_TGT_WLAN;
            end else if (in_rgn(pa, VASM_PCI_IO_BASE, VASM_SZ_1M)) begin
                tgt = VASM_TGT_PCI_IO;
            end else if (in_rgn(pa, VASM_PCI_M01_BASE, VASM_SZ_64K)) begin
                tgt = VASM_TGT_PCI_M01;
            end else if (in_rgn(pa, VASM_PCI_M2_BASE, VASM_SZ_64K)) begin
                tgt = VASM_TGT_PCI_M2;
            end else if (pa >= VASM_PCI_M3_BASE && pa <= (VASM_PCI_M3_BASE | VASM_SZ_208M)) begin
                tgt = VASM_TGT_PCI_M3;
            end else if ((pa & ~32'h0003_ffff) == VASM_PCI_CFG_BASE) begin
                tgt = vasm_tgt_t'({3'h4, pa[17:16]});
            end
        end
        st_nxt.rsp.valid = req_in.valid;
        st_nxt.rsp.paddr = pa;
        st_nxt.rsp.seg = seg;
        st_nxt.rsp.target = exc ? VASM_TGT_NONE : tgt;
        st_nxt.rsp.cacheable = cach;
        st_nxt.rsp.pci_io = !exc && tgt == VASM_TGT_PCI_IO;
        st_nxt.rsp.pci_cfg = !exc && tgt[4:2] == 3'h4;
        st_nxt.rsp.exc = req_in.valid && exc;
        // Refill port
        if (tlb_we_in) begin
            st_nxt.tlb[tlb_idx_in] = tlb_entry_in;
        end
    end

    //--------------------------------------------------------------
    // State register
    //--------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rsp_out = st_r.rsp;
    // boot vector for the core's fetch unit
    assign boot_pc_out = VASM_BOOT_VECTOR;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    AST_USER_PRIV: assert property (
        req_in.valid && !req_in.kernel && req_in.vaddr[31] |=> rsp_out.exc)
        else $error("user access to kernel segment not faulted");
    AST_KCD_ALIAS: assert property (
        req_in.valid && req_in.vaddr[31:29] == 3'h4
        |=> rsp_out.paddr == {3'h0, $past(req_in.vaddr[28:0])})
        else $error("cached direct alias wrong");
    AST_KUD_UNCACHED: assert property (
        req_in.valid && req_in.vaddr[31:29] == 3'h5 |=> !rsp_out.cacheable)
        else $error("uncached segment reported cacheable");
    AST_TOP_IDENT: assert property (
        req_in.valid && req_in.vaddr[31:24] == 8'hff
        |=> rsp_out.paddr == $past(req_in.vaddr))
        else $error("top region not identity");
    AST_BOOT: assert property (
        boot_pc_out == VASM_BOOT_VECTOR)
        else $error("boot vector wrong");
    AST_SDRAM: assert property (
        rsp_out.target == VASM_TGT_SDRAM |-> rsp_out.paddr <= VASM_SDRAM_LAST)
        else $error("SDRAM steer out of range");
    AST_MISS: assert property (
        req_in.valid && !req_in.vaddr[31] && !hit |=> rsp_out.exc)
        else $error("TLB miss not faulted");
    AST_PERIPH_KUD: assert property (
        rsp_out.target inside {VASM_TGT_SFR, VASM_TGT_PCI_IO, VASM_TGT_WLAN}
        |-> rsp_out.seg == VASM_SEG_KUD)
        else $error("peripheral reached outside uncached segment");
    AST_WPROT: assert property (
        req_in.valid && req_in.write && !req_in.vaddr[31] && hit && !hit_e.writable
        |=> rsp_out.exc)
        else $error("write to read-only page not faulted");

    //--------------------------------------------------------------
    // Request shapes and answer checks
    //--------------------------------------------------------------
    // Independent view of which addresses go through the TLB
    assign map_va = !req_in.vaddr[31]
        || (req_in.vaddr[31:30] == 2'h3 && req_in.vaddr < VASM_TOP_DIRECT_BASE);

    // Kernel request; its answer follows one edge later
    sequence s_kernel_req;
        req_in.valid && req_in.kernel;
    endsequence

    // Reset fetch address presented by the core
    sequence s_boot_fetch;
        req_in.valid && req_in.kernel && req_in.vaddr == VASM_BOOT_VECTOR;
    endsequence

    // Mapped address that found an entry
    sequence s_map_hit;
        req_in.valid && map_va && hit;
    endsequence

    AST_VALID_FOLLOW: assert property (
        req_in.valid |=> rsp_out.valid)
        else $error("answer missing for a request");
    AST_IDLE_QUIET: assert property (
        !req_in.valid |=> !rsp_out.valid && !rsp_out.exc)
        else $error("answer or fault without a request");
    AST_KCD_CACHED: assert property (
        s_kernel_req ##0 (req_in.vaddr[31:29] == 3'h4)
        |=> rsp_out.cacheable && !rsp_out.exc)
        else $error("cached direct segment wrong attributes");
    AST_USER_OK: assert property (
        s_map_hit ##0 (!req_in.write && (req_in.kernel || !req_in.vaddr[31]))
        |=> !rsp_out.exc)
        else $error("permitted mapped read faulted");
    AST_TLB_PA: assert property (
        s_map_hit |=> rsp_out.paddr == {$past(hit_e.pfn), $past(req_in.vaddr[VASM_PAGE_BITS-1:0])})
        else $error("mapped physical address wrong");
    AST_TLB_CACHE: assert property (
        s_map_hit |=> rsp_out.cacheable == $past(hit_e.cacheable))
        else $error("mapped cacheability not taken from entry");
    AST_BOOT_FETCH: assert property (
        s_boot_fetch
        |=> rsp_out.target == VASM_TGT_FLASH && rsp_out.paddr == VASM_FLASH_BASE
            && !rsp_out.cacheable)
        else $error("boot fetch not steered to flash");
    AST_FLASH_BASE: assert property (
        s_kernel_req ##0 (req_in.vaddr[31:30] == 2'h2 && req_in.vaddr[28:22] == 7'h7f)
        |=> rsp_out.target == VASM_TGT_FLASH)
        else $error("flash window not steered to flash");
    AST_FLASH_EXT: assert property (
        s_kernel_req ##0 (req_in.vaddr[31:30] == 2'h2
            && req_in.vaddr[28:0] >= VASM_FLASH_EXT_BASE[28:0]
            && req_in.vaddr[28:0] <= VASM_FLASH_EXT_LAST[28:0])
        |=> rsp_out.target == VASM_TGT_FLASH)
        else $error("extended flash window not steered to flash");
    AST_PCI_IO_WIN: assert property (
        rsp_out.pci_io |-> (rsp_out.paddr & ~VASM_SZ_1M) == VASM_PCI_IO_BASE)
        else $error("PCI I/O cycle outside its window");
    AST_CFG_SEL: assert property (
        rsp_out.pci_cfg
        |-> rsp_out.target[1:0] == rsp_out.paddr[17:16] && rsp_out.seg == VASM_SEG_KUD)
        else $error("configuration cycle to wrong device");
    AST_EXC_NONE: assert property (
        rsp_out.exc
        |-> rsp_out.target == VASM_TGT_NONE && !rsp_out.pci_io && !rsp_out.pci_cfg)
        else $error("faulted access still steered");

endmodule : vasm_mapper

// [tb/vasm_core_model.sv]
`timescale 1ns/100ps

// ----------------------------------------
// Core side request source
// ----------------------------------------
// Holds one request until the caller replaces it, so back-to-back issue keeps valid high
module vasm_core_model
    import vasm_pkg::*;
(
    output vasm_req_t req_out
);
    initial begin
        req_out = '0;
    end

    // Caller times this just after a rising edge
    task automatic send(input logic [31:0] va, input logic kern, input logic wr,
                        input logic [5:0] pid);
        req_out = '{valid: 1'b1, vaddr: va, write: wr, kernel: kern, pid: pid};
    endtask : send

    // Address flipped on idle so a stale value cannot match by luck
    task automatic idle();
        req_out.valid = 1'b0;
        req_out.vaddr = ~req_out.vaddr;
    endtask : idle
endmodule : vasm_core_model

// [tb/tb_top.sv]
`timescale 1ns/100ps

module tb_top
    import vasm_pkg::*;
;
    typedef struct {
        logic [31:0] va;
        logic kern;
        vasm_tgt_t tgt;
        logic cach;
        logic exc;
    } vasm_row_t;

    logic mclk_in;
    logic rst_n_in;
    vasm_req_t req;
    logic tlb_we;
    logic [3:0] tlb_idx;
    vasm_tlb_entry_t tlb_ent;
    logic [31:0] boot_pc;
    vasm_rsp_t rsp;
    int num_errors;
    int checks;
    vasm_row_t rows[$];

    vasm_core_model i_core (.req_out(req));

    vasm_mapper #(.ENTRIES(16)) i_vasm_mapper (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .req_in(req),
        .tlb_we_in(tlb_we),
        .tlb_idx_in(tlb_idx),
        .tlb_entry_in(tlb_ent),
        .boot_pc_out(boot_pc),
        .rsp_out(rsp)
    );

    // ----------------------------------------
    // Clock and helpers
    // ----------------------------------------
    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end

    // Inputs always move 1 ns after the edge, away from sampling
    task automatic tick();
        @(posedge mclk_in);
        #1;
    endtask : tick

    task automatic end_sim();
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_rsp(input vasm_rsp_t exp);
        vasm_rsp_t got;
        got = rsp;
        // Address and attribute carry no meaning on a refused access
        if (exp.exc) begin
            got.paddr = exp.paddr;
            got.cacheable = exp.cacheable;
        end
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, rsp, exp);
        end
    endtask : chk_rsp

    // Expected answer; segment follows the top address bits
    function automatic vasm_rsp_t mk(input logic [31:0] va, input logic [31:0] pa,
                                     input vasm_tgt_t t, input logic c, input logic x);
        vasm_rsp_t r;
        r = '0;
        r.valid = 1'b1;
        r.paddr = pa;
        r.seg = !va[31] ? VASM_SEG_USER : va[30] ? VASM_SEG_KMAP :
                va[29] ? VASM_SEG_KUD : VASM_SEG_KCD;
        r.target = x ? VASM_TGT_NONE : t;
        r.cacheable = c;
        r.pci_io = (t == VASM_TGT_PCI_IO);
        r.pci_cfg = (t >= VASM_TGT_PCI_CFG0) && (t <= VASM_TGT_PCI_CFG3);
        r.exc = x;
        return r;
    endfunction : mk

    // Direct map: top region is identity, the rest folds onto the low 512M
    function automatic logic [31:0] dpa(input logic [31:0] va);
        return (va >= 32'hff00_0000) ? va : (va & 32'h1fff_ffff);
    endfunction : dpa

    task automatic look(input logic [31:0] va, input logic k, input logic wr,
                        input logic [5:0] pid, input logic [31:0] pa, input vasm_tgt_t t,
                        input logic c, input logic x);
        i_core.send(va, k, wr, pid);
        tick();
        chk_rsp(mk(va, pa, t, c, x));
    endtask : look

    task automatic add(input logic [31:0] va, input logic k, input vasm_tgt_t t,
                       input logic c, input logic x);
        rows.push_back('{va, k, t, c, x});
    endtask : add

    task automatic tlb_put(input logic [3:0] i, input logic [19:0] vpn,
                           input logic [19:0] pfn, input logic wr, input logic c);
        tlb_we = 1'b1;
        tlb_idx = i;
        tlb_ent = '{1'b1, vpn, pfn, 6'h05, wr, c};
        tick();
        tlb_we = 1'b0;
        // Let an edge pass with the strobe low so back-to-back writes stay apart
        tick();
    endtask : tlb_put

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        num_errors = 0;
        checks = 0;
        rst_n_in = 1'b0;
        tlb_we = 1'b0;
        tlb_idx = '0;
        tlb_ent = '0;
        repeat (8) tick();
        chk_rsp('0);
        chk_word(boot_pc, VASM_BOOT_VECTOR);
        rst_n_in = 1'b1;
        tick();
        add(32'hbfc0_0000, 1, VASM_TGT_FLASH, 0, 0);
        add(32'hbfff_fffc, 1, VASM_TGT_FLASH, 0, 0);
        add(32'h9fc0_0000, 1, VASM_TGT_FLASH, 1, 0);
        add(32'h8000_0100, 1, VASM_TGT_SDRAM, 1, 0);
        add(32'ha3ff_ffff, 1, VASM_TGT_SDRAM, 0, 0);
        add(32'hbe40_0000, 1, VASM_TGT_FLASH, 0, 0);
        add(32'hbeff_ffff, 1, VASM_TGT_FLASH, 0, 0);
        add(32'hbd01_0fff, 1, VASM_TGT_SFR, 0, 0);
        add(32'hbd01_1000, 1, VASM_TGT_MEMC, 0, 0);
        add(32'hbd17_fffc, 1, VASM_TGT_CRYPTO, 0, 0);
        add(32'hbd18_0000, 1, VASM_TGT_MIC, 0, 0);
        add(32'hbd20_0000, 1, VASM_TGT_ETH0, 0, 0);
        add(32'hbd2f_fff0, 1, VASM_TGT_VOICE, 0, 0);
        add(32'hbd30_0000, 1, VASM_TGT_ETH1, 0, 0);
        add(32'hbd4f_ffff, 1, VASM_TGT_WLAN, 0, 0);
        add(32'hbd50_0000, 1, VASM_TGT_PCI_IO, 0, 0);
        add(32'hbd60_ffff, 1, VASM_TGT_PCI_M01, 0, 0);
        add(32'hbd61_0000, 1, VASM_TGT_PCI_M2, 0, 0);
        add(32'hbcff_ffff, 1, VASM_TGT_PCI_M3, 0, 0);
        for (int n = 0; n < 4; n++) begin
            add(32'hbd70_fffc + n * 32'h1_0000, 1, vasm_tgt_t'(5'h10 + 5'(n)), 0, 0);
        end
        add(32'hff00_0010, 1, VASM_TGT_TOP, 1, 0);
        add(32'h8000_0000, 0, VASM_TGT_NONE, 0, 1);
        add(32'h9d01_0000, 1, VASM_TGT_NONE, 1, 0);
        // Rows go back to back with valid held high
        foreach (rows[i]) begin
            look(rows[i].va, rows[i].kern, 0, 6'h05, dpa(rows[i].va), rows[i].tgt,
                 rows[i].cach, rows[i].exc);
        end
        i_core.idle();
        tick();
        chk_word({31'h0, rsp.valid}, 32'h0);
        // TLB: read-only page, kernel page, shadowing by a lower index
        tlb_put(4'hf, 20'h00400, 20'h01234, 1'b0, 1'b1);
        tlb_put(4'h0, 20'hc0001, 20'h00002, 1'b1, 1'b0);
        look(32'h0040_0abc, 0, 0, 6'h05, 32'h0123_4abc, VASM_TGT_SDRAM, 1, 0);
        look(32'h0040_0abc, 1, 0, 6'h05, 32'h0123_4abc, VASM_TGT_SDRAM, 1, 0);
        look(32'h0040_0abc, 0, 1, 6'h05, 32'h0, VASM_TGT_NONE, 0, 1);
        look(32'h0040_0abc, 0, 0, 6'h06, 32'h0, VASM_TGT_NONE, 0, 1);
        look(32'hc000_1004, 1, 1, 6'h05, 32'h0000_2004, VASM_TGT_SDRAM, 0, 0);
        look(32'hc000_1004, 0, 0, 6'h05, 32'h0, VASM_TGT_NONE, 0, 1);
        look(32'h7fff_f000, 0, 0, 6'h05, 32'h0, VASM_TGT_NONE, 0, 1);
        tlb_put(4'h3, 20'h00400, 20'h00777, 1'b1, 1'b1);
        look(32'h0040_0abc, 0, 1, 6'h05, 32'h0077_7abc, VASM_TGT_SDRAM, 1, 0);
        // Reset in mid-run clears the answer at once and empties the TLB
        rst_n_in = 1'b0;
        #1;
        chk_rsp('0);
        tick();
        rst_n_in = 1'b1;
        tick();
        look(32'h0040_0abc, 0, 0, 6'h05, 32'h0, VASM_TGT_NONE, 0, 1);
        end_sim();
    end

    // Hang guard
    initial begin
        repeat (2000) @(posedge mclk_in);
        num_errors++;
        end_sim();
    end
endmodule : tb_top
